// *** ccmrx_pkg.sv ***
package ccmrx_pkg;
  // timing
  localparam int CLK_NS = 50;
  localparam int SCAN_MIN_NS = 480;
  localparam int SCAN_MAX_NS = 1400;
  localparam int SCAN_MIN_CYC = (SCAN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_MAX_CYC = SCAN_MAX_NS / CLK_NS;
  localparam int NUM_TIMERS = 7;
  localparam logic [2:0] MISS_LOSS = 3'h7;
  localparam logic [2:0] PERIOD_INVALID = 3'h0;
  localparam int GID_WORDS = 12;
  // byte addresses
  localparam logic [11:0] ADR_GCTRL = 12'h000;
  localparam logic [11:0] ADR_TICK = 12'h004;
  localparam logic [11:0] ADR_PER0 = 12'h010;
  localparam logic [11:0] ADR_SCAN = 12'h030;
  localparam logic [11:0] ADR_EP0 = 12'h100;
  // word index inside one endpoint window of 0x80 bytes
  localparam logic [4:0] W_CTRL = 5'h00;
  localparam logic [4:0] W_PEER = 5'h01;
  localparam logic [4:0] W_SEQ = 5'h02;
  localparam logic [4:0] W_STKY = 5'h03;
  localparam logic [4:0] W_MASK = 5'h04;
  localparam logic [4:0] W_GOOD = 5'h05;
  localparam logic [4:0] W_BAD = 5'h06;
  localparam logic [4:0] W_MISS = 5'h07;
  localparam logic [4:0] W_GID = 5'h10;
  // endpoint control fields
  localparam int C_ENA = 0;
  localparam int C_GID = 1;
  localparam int C_PID = 2;
  localparam int C_SEQ = 3;
  localparam int C_CPY = 4;
  localparam int C_ONCE = 5;
  localparam int C_LVL = 6;
  localparam int C_PER = 9;
  localparam int C_PRI = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7fff;
  localparam logic [31:0] PEER_MASK = 32'h0000_1fff;
  // endpoint sticky positions
  localparam int S_LVL = 0;
  localparam int S_MMG = 1;
  localparam int S_PEER = 2;
  localparam int S_PINV = 3;
  localparam int S_PER = 4;
  localparam int S_PRI = 5;
  localparam int S_RDI = 6;
  localparam int S_SEQ = 7;
  localparam int S_LOSS = 8;
  localparam int NUM_STKY = 9;
  // global control and scan status fields
  localparam int G_SCAN = 0;
  localparam int G_FORCE = 1;
  localparam int G_ABORT = 2;
  localparam int SS_RUN = 0;
  localparam int SS_BEGUN = 1;
  localparam int SS_DONE = 2;
  localparam int SS_OVR = 3;
  // reset values
  localparam logic [31:0] TICK_RST = 32'h0000_0001;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef struct packed {
    logic vld;
    logic [7:0] ep;
    logic [2:0] level;
    logic [383:0] gid;
    logic [12:0] peer;
    logic [2:0] period;
    logic [2:0] prio;
    logic rdi;
    logic [31:0] seq;
  } ccmrx_frame_type;

  typedef struct packed {
    logic vld;
    logic good;
    logic discard;
    logic cpu_copy;
    logic [7:0] ep;
  } ccmrx_verdict_type;

  typedef enum logic [0:0] {
    SCAN_IDLE = 1'b0,
    SCAN_RUN = 1'b1
  } ccmrx_scan_type;
endpackage

// *** ccmrx_top.sv ***
// Operation
// - enabled endpoint flags frames whose level is below configured level
// - group check compares all 48 id bytes, flags mismerge at equal level
// - peer check flags wrong endpoint id after level and group pass
// - period field zero after level and id checks is invalid-period defect
// - defect frames discarded, sticky bit set, masked stickies raise irq
// - defect frames copied to cpu always or once per arming
// - count bad frames and good frames separately
// - good frame clears miss count, timeout increments, seven means loss
// - period code unlike configured code flags unexpected period
// - priority unlike configured priority flags unexpected priority
// - received remote defect indication sets sticky bit, can raise irq
// - sequence check wants stored plus one, then stored value increments
// - seven timers count a common tick of programmable clock periods
// - each timer times out after programmable ticks and restarts
// - period code n binds endpoint to timer n minus one
// - entering loss state sets loss sticky, own enable makes it irq
// - timeout with scan enabled scans endpoints, 480 to 1400 ns long
// - timeouts during a scan stay pending, next scan follows at once
// - timeout of a timer under its own running scan sets overrun sticky
// - software force starts scan, software abort stops running scan
// - live scan status, sticky bits on scan begin and scan done
// - code 0 invalid, codes 1 to 7 are the seven standard periods
`timescale 1ns/1ps
module ccmrx_top #(
  parameter int NEP = 8, // endpoints, at most scan length
  parameter int TICK_W = 16, // base tick divisor width
  parameter int PER_W = 24 // timer period width
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  input wire logic wb_we_i, // write
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output logic wb_ack_o, // acknowledge
  input wire ccmrx_pkg::ccmrx_frame_type frame_i, // received frame
  output ccmrx_pkg::ccmrx_verdict_type verdict_o, // frame verdict
  output logic [NEP-1:0] loss_o, // per endpoint loss state
  output logic irq_o // interrupt, high
);
  localparam logic [31:0] TICK_MASK = 32'((64'h1 << TICK_W) - 1);
  localparam logic [31:0] PER_MASK = 32'((64'h1 << PER_W) - 1);

  function automatic logic [31:0] bmask(input logic [3:0] s);
    bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    merge = (o & ~bmask(s)) | (n & bmask(s));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic req;
  logic ack_r;
  logic wr;
  logic [31:0] rd;
  logic [31:0] dat_r;
  logic [11:0] ep_off;
  logic [11:0] per_off;
  logic [4:0] ep_n;
  logic [4:0] wi;
  logic ep_ok;
  logic per_hit;
  logic [2:0] pk;
  int eidx;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && ack_r && wb_we_i;
  assign ep_off = wb_adr_i - ccmrx_pkg::ADR_EP0;
  assign ep_n = ep_off[11:7];
  assign wi = ep_off[6:2];
  assign ep_ok = (wb_adr_i >= ccmrx_pkg::ADR_EP0) && (ep_n < 5'(NEP));
  assign eidx = ep_ok ? int'(ep_n) : 0;
  assign per_off = wb_adr_i - ccmrx_pkg::ADR_PER0;
  assign per_hit = (wb_adr_i >= ccmrx_pkg::ADR_PER0) &&
                   (per_off < 12'(4 * ccmrx_pkg::NUM_TIMERS));
  assign pk = per_off[4:2];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] ctrl_r [NEP];
  logic [31:0] ctrl_nxt [NEP];
  logic [31:0] peer_r [NEP];
  logic [31:0] peer_nxt [NEP];
  logic [31:0] seq_r [NEP];
  logic [31:0] seq_nxt [NEP];
  logic [31:0] gid_r [NEP*ccmrx_pkg::GID_WORDS];
  logic [31:0] gid_nxt [NEP*ccmrx_pkg::GID_WORDS];
  logic [ccmrx_pkg::NUM_STKY-1:0] stky_r [NEP];
  logic [ccmrx_pkg::NUM_STKY-1:0] stky_nxt [NEP];
  logic [ccmrx_pkg::NUM_STKY-1:0] imask_r [NEP];
  logic [ccmrx_pkg::NUM_STKY-1:0] imask_nxt [NEP];
  logic [31:0] good_r [NEP];
  logic [31:0] good_nxt [NEP];
  logic [31:0] bad_r [NEP];
  logic [31:0] bad_nxt [NEP];
  logic [2:0] miss_r [NEP];
  logic [2:0] miss_nxt [NEP];
  logic [NEP-1:0] once_r;
  logic [NEP-1:0] once_nxt;
  logic [NEP-1:0] loss_r;
  logic [NEP-1:0] loss_nxt;
  ccmrx_pkg::ccmrx_verdict_type vd_r;
  ccmrx_pkg::ccmrx_verdict_type vd_nxt;

  logic scan_en_r;
  logic scan_en_nxt;
  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic [31:0] per_r [ccmrx_pkg::NUM_TIMERS];
  logic [31:0] per_nxt [ccmrx_pkg::NUM_TIMERS];
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_cnt_nxt;
  logic [PER_W-1:0] tcnt_r [ccmrx_pkg::NUM_TIMERS];
  logic [PER_W-1:0] tcnt_nxt [ccmrx_pkg::NUM_TIMERS];
  logic [ccmrx_pkg::NUM_TIMERS-1:0] tmo;
  logic tick;
  ccmrx_pkg::ccmrx_scan_type st_r;
  ccmrx_pkg::ccmrx_scan_type st_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [ccmrx_pkg::NUM_TIMERS-1:0] mask_r;
  logic [ccmrx_pkg::NUM_TIMERS-1:0] mask_nxt;
  logic [ccmrx_pkg::NUM_TIMERS-1:0] pend_r;
  logic [ccmrx_pkg::NUM_TIMERS-1:0] pend_nxt;
  logic [3:1] sst_r;
  logic [3:1] sst_nxt;
  logic force_p;
  logic abort_p;

  ////////////////////////////////////////////////////////////////////////
  // frame checks
  ccmrx_pkg::ccmrx_frame_type f;
  int idx;
  logic [31:0] fc;
  logic [383:0] gcat;
  logic hdl;
  logic e_lvl;
  logic e_mmg;
  logic e_peer;
  logic e_pinv;
  logic e_per;
  logic e_pri;
  logic bad;
  logic good;
  logic seq_bad;
  logic copy;

  assign f = frame_i;
  assign idx = (f.ep < 8'(NEP)) ? int'(f.ep) : 0;
  assign fc = ctrl_r[idx];

  always_comb begin
    for (int k = 0; k < ccmrx_pkg::GID_WORDS; k++) begin
      gcat[k*32 +: 32] = gid_r[idx*ccmrx_pkg::GID_WORDS+k];
    end
  end

  // levels above the configured one are plain data and not handled here
  assign hdl = f.vld && (f.ep < 8'(NEP)) && fc[ccmrx_pkg::C_ENA] &&
               (f.level <= fc[ccmrx_pkg::C_LVL +: 3]);
  assign e_lvl = f.level < fc[ccmrx_pkg::C_LVL +: 3];
  assign e_mmg = !e_lvl && fc[ccmrx_pkg::C_GID] && (f.gid != gcat);
  assign e_peer = !e_lvl && !e_mmg && fc[ccmrx_pkg::C_PID] &&
                  (f.peer != peer_r[idx][12:0]);
  assign e_pinv = !e_lvl && !e_mmg && !e_peer &&
                  (f.period == ccmrx_pkg::PERIOD_INVALID);
  assign e_per = !e_lvl && !e_mmg && !e_peer && !e_pinv &&
                 (f.period != fc[ccmrx_pkg::C_PER +: 3]);
  assign e_pri = !e_lvl && !e_mmg && !e_peer && !e_pinv && !e_per &&
                 (f.prio != fc[ccmrx_pkg::C_PRI +: 3]);
  assign bad = e_lvl || e_mmg || e_peer || e_pinv || e_per || e_pri;
  assign good = hdl && !bad;
  assign seq_bad = good && fc[ccmrx_pkg::C_SEQ] &&
                   (f.seq != seq_r[idx] + 32'h1);
  assign copy = hdl && bad && (fc[ccmrx_pkg::C_CPY] ||
                (fc[ccmrx_pkg::C_ONCE] && !once_r[idx]));

  ////////////////////////////////////////////////////////////////////////
  // endpoint registers
  always_comb begin
    logic [ccmrx_pkg::NUM_STKY-1:0] set;
    logic [ccmrx_pkg::NUM_STKY-1:0] clr;
    logic [2:0] pc;
    logic visit;
    set = '0;
    clr = '0;
    pc = 3'h0;
    visit = 1'b0;
    gid_nxt = gid_r;
    vd_nxt = '{vld: hdl, good: good, discard: hdl && bad,
               cpu_copy: copy, ep: f.ep};
    for (int i = 0; i < NEP; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      peer_nxt[i] = peer_r[i];
      seq_nxt[i] = seq_r[i];
      imask_nxt[i] = imask_r[i];
      good_nxt[i] = good_r[i];
      bad_nxt[i] = bad_r[i];
      miss_nxt[i] = miss_r[i];
      once_nxt[i] = once_r[i];
      set = '0;
      clr = '0;
      if (wr && ep_ok && eidx == i) begin
        case (wi)
          ccmrx_pkg::W_CTRL: begin
            ctrl_nxt[i] = merge(ctrl_r[i], wb_dat_i, wb_sel_i) &
                          ccmrx_pkg::CTRL_MASK;
            once_nxt[i] = 1'b0;
          end
          ccmrx_pkg::W_PEER: peer_nxt[i] = merge(peer_r[i], wb_dat_i,
                                wb_sel_i) & ccmrx_pkg::PEER_MASK;
          ccmrx_pkg::W_SEQ: seq_nxt[i] = merge(seq_r[i], wb_dat_i, wb_sel_i);
          ccmrx_pkg::W_STKY: clr = ccmrx_pkg::NUM_STKY'(wb_dat_i &
                                   bmask(wb_sel_i));
          ccmrx_pkg::W_MASK: imask_nxt[i] = ccmrx_pkg::NUM_STKY'(merge(
                32'(imask_r[i]), wb_dat_i, wb_sel_i));
          default: begin
            for (int k = 0; k < ccmrx_pkg::GID_WORDS; k++) begin
              if (wi == ccmrx_pkg::W_GID + 5'(k)) begin
                gid_nxt[i*ccmrx_pkg::GID_WORDS+k] = merge(
                  gid_r[i*ccmrx_pkg::GID_WORDS+k], wb_dat_i, wb_sel_i);
              end
            end
          end
        endcase
      end
      if (hdl && idx == i) begin
        set[ccmrx_pkg::S_LVL] = e_lvl;
        set[ccmrx_pkg::S_MMG] = e_mmg;
        set[ccmrx_pkg::S_PEER] = e_peer;
        set[ccmrx_pkg::S_PINV] = e_pinv;
        set[ccmrx_pkg::S_PER] = e_per;
        set[ccmrx_pkg::S_PRI] = e_pri;
        set[ccmrx_pkg::S_RDI] = f.rdi;
        set[ccmrx_pkg::S_SEQ] = seq_bad;
        if (good && fc[ccmrx_pkg::C_SEQ]) begin
          seq_nxt[i] = seq_r[i] + 32'h1;
        end
        if (good) begin
          good_nxt[i] = good_r[i] + 32'h1;
        end else begin
          bad_nxt[i] = bad_r[i] + 32'h1;
        end
        if (copy && !ctrl_r[i][ccmrx_pkg::C_CPY]) begin
          once_nxt[i] = 1'b1;
        end
      end
      pc = ctrl_r[i][ccmrx_pkg::C_PER +: 3];
      visit = (st_r == ccmrx_pkg::SCAN_RUN) && (cnt_r == 5'(i)) &&
              ctrl_r[i][ccmrx_pkg::C_ENA] && (pc != 3'h0) &&
              mask_r[pc - 3'h1];
      if (good && idx == i) begin
        miss_nxt[i] = 3'h0;
      end else if (visit && miss_r[i] != ccmrx_pkg::MISS_LOSS) begin
        miss_nxt[i] = miss_r[i] + 3'h1;
      end
      loss_nxt[i] = miss_nxt[i] == ccmrx_pkg::MISS_LOSS;
      set[ccmrx_pkg::S_LOSS] = loss_nxt[i] && !loss_r[i];
      stky_nxt[i] = (stky_r[i] & ~clr) | set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NEP; i++) begin
        ctrl_r[i] <= ccmrx_pkg::REG_RST;
        peer_r[i] <= ccmrx_pkg::REG_RST;
        seq_r[i] <= ccmrx_pkg::REG_RST;
        stky_r[i] <= '0;
        imask_r[i] <= '0;
        good_r[i] <= ccmrx_pkg::REG_RST;
        bad_r[i] <= ccmrx_pkg::REG_RST;
        miss_r[i] <= 3'h0;
      end
      for (int j = 0; j < NEP*ccmrx_pkg::GID_WORDS; j++) begin
        gid_r[j] <= ccmrx_pkg::REG_RST;
      end
      once_r <= '0;
      loss_r <= '0;
      vd_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      peer_r <= peer_nxt;
      seq_r <= seq_nxt;
      stky_r <= stky_nxt;
      imask_r <= imask_nxt;
      good_r <= good_nxt;
      bad_r <= bad_nxt;
      miss_r <= miss_nxt;
      gid_r <= gid_nxt;
      once_r <= once_nxt;
      loss_r <= loss_nxt;
      vd_r <= vd_nxt;
    end
  end

  assign verdict_o = vd_r;
  assign loss_o = loss_r;

  always_comb begin
    irq_o = 1'b0;
    for (int i = 0; i < NEP; i++) begin
      irq_o = irq_o || |(stky_r[i] & imask_r[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // base tick, loss timers, scan engine
  assign force_p = wr && wb_adr_i == ccmrx_pkg::ADR_GCTRL &&
                   wb_sel_i[0] && wb_dat_i[ccmrx_pkg::G_FORCE];
  assign abort_p = wr && wb_adr_i == ccmrx_pkg::ADR_GCTRL &&
                   wb_sel_i[0] && wb_dat_i[ccmrx_pkg::G_ABORT];
  assign tick = (div_r[TICK_W-1:0] <= TICK_W'(1)) ||
                (tick_cnt_r == div_r[TICK_W-1:0] - TICK_W'(1));

  always_comb begin
    logic [3:1] sset;
    logic [3:1] sclr;
    sset = '0;
    sclr = '0;
    scan_en_nxt = scan_en_r;
    div_nxt = div_r;
    per_nxt = per_r;
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + TICK_W'(1);
    for (int k = 0; k < ccmrx_pkg::NUM_TIMERS; k++) begin
      tmo[k] = 1'b0;
      tcnt_nxt[k] = tcnt_r[k];
      if (per_r[k][PER_W-1:0] == '0) begin
        tcnt_nxt[k] = '0;
      end else if (tick) begin
        tmo[k] = tcnt_r[k] == per_r[k][PER_W-1:0] - PER_W'(1);
        tcnt_nxt[k] = tmo[k] ? '0 : tcnt_r[k] + PER_W'(1);
      end
    end
    if (wr) begin
      if (wb_adr_i == ccmrx_pkg::ADR_GCTRL && wb_sel_i[0]) begin
        scan_en_nxt = wb_dat_i[ccmrx_pkg::G_SCAN];
      end
      if (wb_adr_i == ccmrx_pkg::ADR_TICK) begin
        div_nxt = merge(div_r, wb_dat_i, wb_sel_i) & TICK_MASK;
      end
      if (per_hit) begin
        per_nxt[pk] = merge(per_r[pk], wb_dat_i, wb_sel_i) & PER_MASK;
      end
      if (wb_adr_i == ccmrx_pkg::ADR_SCAN) begin
        sclr = wb_dat_i[3:1] & {3{wb_sel_i[0]}};
      end
    end
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    pend_nxt = pend_r | (tmo & {ccmrx_pkg::NUM_TIMERS{scan_en_r}});
    case (st_r)
      ccmrx_pkg::SCAN_IDLE: begin
        if (force_p || (scan_en_r && pend_r != '0)) begin
          st_nxt = ccmrx_pkg::SCAN_RUN;
          cnt_nxt = 5'h0;
          mask_nxt = pend_r;
          pend_nxt = tmo & {ccmrx_pkg::NUM_TIMERS{scan_en_r}};
          sset[ccmrx_pkg::SS_BEGUN] = 1'b1;
        end
      end
      ccmrx_pkg::SCAN_RUN: begin
        sset[ccmrx_pkg::SS_OVR] = |(tmo & mask_r);
        if (abort_p) begin
          st_nxt = ccmrx_pkg::SCAN_IDLE;
        end else if (cnt_r == 5'(ccmrx_pkg::SCAN_MIN_CYC - 1)) begin
          st_nxt = ccmrx_pkg::SCAN_IDLE;
          sset[ccmrx_pkg::SS_DONE] = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 5'h1;
        end
      end
      default: st_nxt = ccmrx_pkg::SCAN_IDLE;
    endcase
    sst_nxt = (sst_r & ~sclr) | sset;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_en_r <= 1'b0;
      div_r <= ccmrx_pkg::TICK_RST;
      for (int k = 0; k < ccmrx_pkg::NUM_TIMERS; k++) begin
        per_r[k] <= ccmrx_pkg::REG_RST;
        tcnt_r[k] <= '0;
      end
      tick_cnt_r <= '0;
      st_r <= ccmrx_pkg::SCAN_IDLE;
      cnt_r <= 5'h0;
      mask_r <= '0;
      pend_r <= '0;
      sst_r <= '0;
    end else begin
      scan_en_r <= scan_en_nxt;
      div_r <= div_nxt;
      per_r <= per_nxt;
      tcnt_r <= tcnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      pend_r <= pend_nxt;
      sst_r <= sst_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and bus answer
  always_comb begin
    rd = 32'h0;
    if (ep_ok) begin
      case (wi)
        ccmrx_pkg::W_CTRL: rd = ctrl_r[eidx];
        ccmrx_pkg::W_PEER: rd = peer_r[eidx];
        ccmrx_pkg::W_SEQ: rd = seq_r[eidx];
        ccmrx_pkg::W_STKY: rd = 32'(stky_r[eidx]);
        ccmrx_pkg::W_MASK: rd = 32'(imask_r[eidx]);
        ccmrx_pkg::W_GOOD: rd = good_r[eidx];
        ccmrx_pkg::W_BAD: rd = bad_r[eidx];
        ccmrx_pkg::W_MISS: rd = 32'(miss_r[eidx]);
        default: begin
          for (int k = 0; k < ccmrx_pkg::GID_WORDS; k++) begin
            if (wi == ccmrx_pkg::W_GID + 5'(k)) begin
              rd = gid_r[eidx*ccmrx_pkg::GID_WORDS+k];
            end
          end
        end
      endcase
    end else if (per_hit) begin
      rd = per_r[pk];
    end else if (wb_adr_i == ccmrx_pkg::ADR_GCTRL) begin
      rd = 32'(scan_en_r);
    end else if (wb_adr_i == ccmrx_pkg::ADR_TICK) begin
      rd = div_r;
    end else if (wb_adr_i == ccmrx_pkg::ADR_SCAN) begin
      rd = {28'h0, sst_r, st_r == ccmrx_pkg::SCAN_RUN};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= (req && !ack_r) ? rd : dat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  int run_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || st_r != ccmrx_pkg::SCAN_RUN) begin
      run_len <= 0;
    end else begin
      run_len <= run_len + 1;
    end
  end

  scan_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    run_len < ccmrx_pkg::SCAN_MAX_CYC)
    else $error("scan runs too long");
  scan_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(st_r == ccmrx_pkg::SCAN_RUN) && !$past(abort_p)
      |-> sst_r[ccmrx_pkg::SS_DONE] && $past(run_len) == 9)
    else $error("scan done without flag or wrong length");
  scan_begin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_r == ccmrx_pkg::SCAN_RUN) |-> sst_r[ccmrx_pkg::SS_BEGUN])
    else $error("scan begin flag missing");
  overrun_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ccmrx_pkg::SCAN_RUN && (tmo & mask_r) != '0)
      |=> sst_r[ccmrx_pkg::SS_OVR])
    else $error("overrun flag missing");
  pend_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(st_r == ccmrx_pkg::SCAN_RUN) && pend_r != '0 && scan_en_r)
      |=> st_r == ccmrx_pkg::SCAN_RUN)
    else $error("pending scan did not follow");
  good_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vd_r.vld && vd_r.good |-> miss_r[vd_r.ep[2:0]] == 3'h0)
    else $error("good frame left miss count");
  miss_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    miss_r[0] == 3'h7 && !(vd_r.good && vd_r.ep == 8'h0)
      |-> $past(miss_r[0]) == 3'h7 || stky_r[0][ccmrx_pkg::S_LOSS])
    else $error("loss entry without sticky");
  good_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vd_r.vld && vd_r.ep == 8'h0
      |-> (good_r[0] + bad_r[0]) == ($past(good_r[0]) + $past(bad_r[0])
           + 32'h1))
    else $error("frame counters not stepped once");
  copy_disc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    vd_r.cpu_copy |-> vd_r.discard && vd_r.vld)
    else $error("copy of a frame that was not discarded");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule

// *** ccmrx_src.sv ***
`timescale 1ns/1ps
module ccmrx_src (
  input wire logic clk_i, // system clock
  output ccmrx_pkg::ccmrx_frame_type frame_o // frame into block
);
  initial frame_o = '0;
  // one-cycle frame; idle fields toggle so stale values never match
  task automatic send(input ccmrx_pkg::ccmrx_frame_type f);
    @(posedge clk_i);
    frame_o <= f;
    @(posedge clk_i);
    frame_o <= {1'b0, ~f[$bits(f)-2:0]};
  endtask
endmodule

// *** ccmrx_top_tb.sv ***
`timescale 1ns/1ps
module ccmrx_top_tb;
  localparam logic [2:0] G = 3'h4;
  localparam logic [2:0] B = 3'h3;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0, rd, s;
  logic [12:0] p;
  logic [3:0] sel = '0;
  logic [7:0] loss;
  logic ack, irq;
  integer seed = 50;
  int num_errors = 0, check_count = 0;
  int lvt[6] = '{2, 3, 3, 3, 3, 3};
  int pet[6] = '{1, 1, 1, 0, 2, 1};
  int prt[6] = '{2, 2, 2, 2, 2, 5};
  logic [2:0] eq[$];
  logic [31:0] rq[$];
  ccmrx_pkg::ccmrx_frame_type fr;
  ccmrx_pkg::ccmrx_verdict_type vd;
  always #25 clk_i = ~clk_i;
  ccmrx_src src (.clk_i(clk_i), .frame_o(fr));
  ccmrx_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(sel),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .frame_i(fr),
    .verdict_o(vd), .loss_o(loss), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [11:0] ea(input logic [4:0] w);
    return ccmrx_pkg::ADR_EP0 + {5'h00, w, 2'h0};
  endfunction
  task automatic wb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic frm(input logic [2:0] lv, pe, pr, input logic g, rdi,
      input logic [12:0] pd, input logic [31:0] sq, input logic [2:0] e);
    ccmrx_pkg::ccmrx_frame_type f;
    f = '0;
    f.vld = 1'b1;
    f.level = lv;
    f.gid[0] = g;
    f.peer = p ^ pd;
    f.period = pe;
    f.prio = pr;
    f.rdi = rdi;
    f.seq = sq;
    if (e != 3'h0)
      eq.push_back(e);
    src.send(f);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (vd.vld === 1'b1)
      chk({vd.ep, vd.good, vd.discard, vd.cpu_copy},
          eq.size() ? eq.pop_front() : 3'h7);
    if (ack === 1'b1 && we === 1'b0)
      chk(rd, rq.pop_front());
  end
  initial begin
    #(20000 * 50);
    num_errors++;
    give_verdict();
  end
  initial begin
    s = $random(seed);
    p = 13'($random(seed));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdx(ccmrx_pkg::ADR_TICK, ccmrx_pkg::TICK_RST);
    rdx(12'h0fc, 32'h0);
    wb(1'b1, ea(ccmrx_pkg::W_PEER), {19'h0, p});
    wb(1'b1, ea(ccmrx_pkg::W_SEQ), s);
    wb(1'b1, ea(ccmrx_pkg::W_CTRL), 32'h0000_22df);
    wb(1'b1, ea(ccmrx_pkg::W_MASK), 32'h0000_0040);
    frm(3'h3, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s + 1, G);
    rdx(ea(ccmrx_pkg::W_SEQ), s + 1);
    frm(3'h3, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s + 7, G);
    rdx(ea(ccmrx_pkg::W_STKY), 32'h80);
    wb(1'b1, ea(ccmrx_pkg::W_STKY), 32'h0000_ffff);
    // one defect per frame, each flags its own sticky bit
    for (int i = 0; i < 6; i++) begin
      frm(3'(lvt[i]), 3'(pet[i]), 3'(prt[i]),
          i == 1, 1'b0, 13'(i == 2), s, B);
      rdx(ea(ccmrx_pkg::W_STKY), 32'h1 << i);
      wb(1'b1, ea(ccmrx_pkg::W_STKY), 32'h0000_ffff);
    end
    frm(3'h4, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s, 3'h0);
    frm(3'h3, 3'h1, 3'h2, 1'b0, 1'b1, 13'h0, s + 3, G);
    @(posedge clk_i);
    chk(irq, 1);
    wb(1'b1, ea(ccmrx_pkg::W_STKY), 32'h0000_0040);
    rdx(ea(ccmrx_pkg::W_STKY), 32'h0);
    chk(irq, 0);
    rdx(ea(ccmrx_pkg::W_GOOD), 32'h3);
    rdx(ea(ccmrx_pkg::W_BAD), 32'h6);
    wb(1'b1, ccmrx_pkg::ADR_PER0, 32'd20);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h1);
    for (int i = 0; i < 600 && loss[0] !== 1'b1; i++) @(posedge clk_i);
    chk(loss[0], 1);
    repeat (100) @(posedge clk_i);
    rdx(ea(ccmrx_pkg::W_MISS), 32'h7);
    rdx(ea(ccmrx_pkg::W_STKY), 32'h100);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h0);
    repeat (30) @(posedge clk_i);
    rdx(ccmrx_pkg::ADR_SCAN, 32'h6);
    wb(1'b1, ccmrx_pkg::ADR_SCAN, 32'hf);
    // short timer 1 keeps timing out under its own scan
    wb(1'b1, ccmrx_pkg::ADR_PER0 + 12'h4, 32'd4);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h1);
    repeat (40) @(posedge clk_i);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h0);
    wb(1'b1, ccmrx_pkg::ADR_PER0, 32'h0);
    wb(1'b1, ccmrx_pkg::ADR_PER0 + 12'h4, 32'h0);
    repeat (30) @(posedge clk_i);
    rdx(ccmrx_pkg::ADR_SCAN, 32'he);
    wb(1'b1, ccmrx_pkg::ADR_SCAN, 32'hf);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h2);
    repeat (20) @(posedge clk_i);
    rdx(ccmrx_pkg::ADR_SCAN, 32'h6);
    wb(1'b1, ccmrx_pkg::ADR_SCAN, 32'hf);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h2);
    rdx(ccmrx_pkg::ADR_SCAN, 32'h3);
    wb(1'b1, ccmrx_pkg::ADR_GCTRL, 32'h4);
    rdx(ccmrx_pkg::ADR_SCAN, 32'h2);
    // copy once: first bad frame goes to cpu, the next does not
    wb(1'b1, ea(ccmrx_pkg::W_CTRL), 32'h0000_22ef);
    frm(3'h2, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s, B);
    frm(3'h2, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s, 3'h2);
    frm(3'h3, 3'h1, 3'h2, 1'b0, 1'b0, 13'h0, s + 4, G);
    @(posedge clk_i);
    chk(loss[0], 0);
    repeat (3) @(posedge clk_i);
    chk(eq.size(), 0);
    give_verdict();
  end
endmodule
